// >>> design/fpec_defines.svh
// Constants of the flash program/erase command sequencer.
// Assumes a 40 MHz clock and 16-bit host data with commands in the low byte.
`ifndef FPEC_DEFINES_SVH
`define FPEC_DEFINES_SVH

`define FPEC_ADDR_W 22
`define FPEC_DATA_W 16
`define FPEC_SECT_N 128
`define FPEC_SECT_LSB 15

`define FPEC_UNLOCK1_ADDR 11'h555
`define FPEC_UNLOCK2_ADDR 11'h2aa
`define FPEC_UNLOCK1_DATA 8'haa
`define FPEC_UNLOCK2_DATA 8'h55

`define FPEC_CMD_PROG 8'ha0
`define FPEC_CMD_ERASE_SETUP 8'h80
`define FPEC_CMD_CHIP_ERASE 8'h10
`define FPEC_CMD_SECT_ERASE 8'h30
`define FPEC_CMD_BYPASS 8'h20
`define FPEC_CMD_BYPASS_EXIT1 8'h90
`define FPEC_CMD_BYPASS_EXIT2 8'h00
`define FPEC_CMD_RESET 8'hf0
`define FPEC_CMD_SUSPEND 8'hb0
`define FPEC_CMD_RESUME 8'h30

`define FPEC_BIT_POLL 7
`define FPEC_BIT_TOGGLE_A 6
`define FPEC_BIT_TLE 5
`define FPEC_BIT_TIMER 3
`define FPEC_BIT_TOGGLE_B 2

`define FPEC_CLK_PERIOD_NS 25
`define FPEC_WIN_MIN_NS 35000
`define FPEC_WIN_CYC ((`FPEC_WIN_MIN_NS + `FPEC_CLK_PERIOD_NS - 1) / `FPEC_CLK_PERIOD_NS)
`define FPEC_WIN_W 11

`endif

// >>> design/fpec_pkg.sv
// Types of the flash program/erase command sequencer.
// Assumes fpec_defines.svh supplies the numeric constants.
package fpec_pkg;
   typedef enum logic [3:0] {
      FPEC_READ,
      FPEC_UL1,
      FPEC_UL2,
      FPEC_PSETUP,
      FPEC_ESETUP,
      FPEC_EUL1,
      FPEC_EUL2,
      FPEC_WINDOW,
      FPEC_PROG,
      FPEC_ERASE,
      FPEC_SUSP,
      FPEC_FAIL,
      FPEC_BYP,
      FPEC_BYP_PSETUP,
      FPEC_BYP_ESETUP,
      FPEC_BYP_EXIT
   } fpec_state_t;

   typedef enum logic [1:0] {
      FPEC_PH_PREPROG,
      FPEC_PH_VERIFY,
      FPEC_PH_ERASE
   } fpec_phase_t;
endpackage

// >>> design/fpec_cmd_fsm.sv
// Command state machine of one flash bank: program, bypass, chip and sector erase.
// Assumes host writes arrive as one-cycle strobes on clk_i and an array engine
// outside performs pulses and reports completion on op_done_i / op_fail_i.
// Behaviour
// - Four writes launch a standard word program
// - Program completion returns bank to read mode
// - Report progress on poll and toggle bits
// - Ignore all commands while program runs
// - Hardware reset aborts program immediately
// - Setting a zero bit flags time limit
// - Two unlocks plus 20h enter bypass mode
// - Bypass program is A0h then address/data
// - Bypass mode accepts only bypass commands
// - 90h then 00h leaves bypass mode
// - High acceleration input forces bypass mode
// - Bypass chip erase needs two writes
// - Six writes start a chip erase
// - Erase preprograms and verifies before erasing
// - Chip erase ignores commands; reset aborts
// - Six writes with sector address request erase
// - Window of at least 35 us collects sectors
// - Other command in window returns to read
// - Erase timer bit shows window state
// - Erasing bank reads status, others array
// - Running sector erase accepts only suspend
// - Suspend in window suspends at once
// - Reset between cycles returns to read, except after A0h, where the write is programmed as data
`include "fpec_defines.svh"

module fpec_cmd_fsm (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic hw_reset_n_i,
   input wire logic accel_program_input_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [`FPEC_ADDR_W-1:0] addr_i,
   input wire logic [`FPEC_DATA_W-1:0] wdata_i,
   input wire logic rd_bank_hit_i,
   input wire logic [`FPEC_DATA_W-1:0] array_rd_data_i,
   input wire logic [`FPEC_DATA_W-1:0] old_data_i,
   input wire logic op_done_i,
   input wire logic op_fail_i,
   output logic [`FPEC_DATA_W-1:0] rd_data_o,
   output logic prog_start_o,
   output logic [`FPEC_ADDR_W-1:0] prog_addr_o,
   output logic [`FPEC_DATA_W-1:0] prog_data_o,
   output logic erase_start_o,
   output logic erase_chip_o,
   output logic [`FPEC_SECT_N-1:0] erase_sectors_o,
   output logic [1:0] erase_phase_o,
   output logic busy_o,
   output logic bypass_o
);

   // Commands sit in the low byte; unlock checks use the low address bits only
   function automatic logic is_cmd(input logic [`FPEC_DATA_W-1:0] d, input logic [7:0] c);
      is_cmd = (d[7:0] == c);
   endfunction

   function automatic logic is_unlock(input logic [`FPEC_ADDR_W-1:0] a,
                                      input logic [`FPEC_DATA_W-1:0] d,
                                      input logic first);
      logic [10:0] ua;
      logic [7:0] ud;
      ua = first ? `FPEC_UNLOCK1_ADDR : `FPEC_UNLOCK2_ADDR;
      ud = first ? `FPEC_UNLOCK1_DATA : `FPEC_UNLOCK2_DATA;
      is_unlock = (a[10:0] == ua) && (d[7:0] == ud);
   endfunction

   function automatic logic [6:0] sect_of(input logic [`FPEC_ADDR_W-1:0] a);
      sect_of = a[`FPEC_ADDR_W-1:`FPEC_SECT_LSB];
   endfunction

   // Pin synchronisers: hardware reset and acceleration come from off-chip
   logic hwr_meta_q, hwr_sync_q, acc_meta_q, acc_sync_q;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hwr_meta_q <= 1'b1;
         hwr_sync_q <= 1'b1;
         acc_meta_q <= 1'b0;
         acc_sync_q <= 1'b0;
      end
      else
      begin
         hwr_meta_q <= hw_reset_n_i;
         hwr_sync_q <= hwr_meta_q;
         acc_meta_q <= accel_program_input_i;
         acc_sync_q <= acc_meta_q;
      end
   end

   logic abort;
   assign abort = ~hwr_sync_q;

   fpec_pkg::fpec_state_t state_q, state_d;
   fpec_pkg::fpec_phase_t phase_q, phase_d;
   logic bypass_q, bypass_d;
   logic [`FPEC_WIN_W-1:0] win_cnt_q, win_cnt_d;
   logic [`FPEC_ADDR_W-1:0] pa_q, pa_d;
   logic [`FPEC_DATA_W-1:0] pd_q, pd_d;
   logic [`FPEC_SECT_N-1:0] sect_q, sect_d;
   logic chip_q, chip_d;
   logic pstart_q, pstart_d, estart_q, estart_d;
   logic tle_q, tle_d;

   logic byp_mode;
   assign byp_mode = bypass_q | acc_sync_q;

   // Return point after an operation or an aborted sequence
   fpec_pkg::fpec_state_t idle_st;
   assign idle_st = byp_mode ? fpec_pkg::FPEC_BYP : fpec_pkg::FPEC_READ;

   always_comb
   begin
      state_d = state_q;
      phase_d = phase_q;
      bypass_d = bypass_q;
      win_cnt_d = win_cnt_q;
      pa_d = pa_q;
      pd_d = pd_q;
      sect_d = sect_q;
      chip_d = chip_q;
      pstart_d = 1'b0;
      estart_d = 1'b0;
      tle_d = tle_q;
      if (abort)
      begin
         // Pin reset terminates any operation and drops bypass
         state_d = fpec_pkg::FPEC_READ;
         bypass_d = 1'b0;
         sect_d = '0;
         chip_d = 1'b0;
         tle_d = 1'b0;
      end
      else
      begin
         unique case (state_q)
            fpec_pkg::FPEC_READ:
               if (wr_i && is_unlock(addr_i, wdata_i, 1'b1))
                  state_d = fpec_pkg::FPEC_UL1;
            fpec_pkg::FPEC_UL1:
               if (wr_i)
                  state_d = is_unlock(addr_i, wdata_i, 1'b0) ? fpec_pkg::FPEC_UL2
                            : fpec_pkg::FPEC_READ;
            fpec_pkg::FPEC_UL2:
               if (wr_i)
               begin
                  if (addr_i[10:0] == `FPEC_UNLOCK1_ADDR && is_cmd(wdata_i, `FPEC_CMD_PROG))
                     state_d = fpec_pkg::FPEC_PSETUP;
                  else if (addr_i[10:0] == `FPEC_UNLOCK1_ADDR
                           && is_cmd(wdata_i, `FPEC_CMD_ERASE_SETUP))
                     state_d = fpec_pkg::FPEC_ESETUP;
                  else if (addr_i[10:0] == `FPEC_UNLOCK1_ADDR
                           && is_cmd(wdata_i, `FPEC_CMD_BYPASS))
                  begin
                     state_d = fpec_pkg::FPEC_BYP;
                     bypass_d = 1'b1;
                  end
                  else
                     state_d = fpec_pkg::FPEC_READ;
               end
            fpec_pkg::FPEC_PSETUP, fpec_pkg::FPEC_BYP_PSETUP:
               if (wr_i)
               begin
                  // Final program write carries address and data
                  state_d = fpec_pkg::FPEC_PROG;
                  pa_d = addr_i;
                  pd_d = wdata_i;
                  pstart_d = 1'b1;
                  tle_d = 1'b0;
               end
            fpec_pkg::FPEC_ESETUP:
               if (wr_i)
                  state_d = is_unlock(addr_i, wdata_i, 1'b1) ? fpec_pkg::FPEC_EUL1
                            : fpec_pkg::FPEC_READ;
            fpec_pkg::FPEC_EUL1:
               if (wr_i)
                  state_d = is_unlock(addr_i, wdata_i, 1'b0) ? fpec_pkg::FPEC_EUL2
                            : fpec_pkg::FPEC_READ;
            fpec_pkg::FPEC_EUL2, fpec_pkg::FPEC_BYP_ESETUP:
               if (wr_i)
               begin
                  if (is_cmd(wdata_i, `FPEC_CMD_CHIP_ERASE)
                      && (state_q == fpec_pkg::FPEC_BYP_ESETUP
                          || addr_i[10:0] == `FPEC_UNLOCK1_ADDR))
                  begin
                     // Chip erase starts at once, no window
                     state_d = fpec_pkg::FPEC_ERASE;
                     chip_d = 1'b1;
                     sect_d = '1;
                     phase_d = fpec_pkg::FPEC_PH_PREPROG;
                     estart_d = 1'b1;
                     tle_d = 1'b0;
                  end
                  else if (is_cmd(wdata_i, `FPEC_CMD_SECT_ERASE))
                  begin
                     state_d = fpec_pkg::FPEC_WINDOW;
                     chip_d = 1'b0;
                     sect_d = '0;
                     sect_d[sect_of(addr_i)] = 1'b1;
                     win_cnt_d = `FPEC_WIN_W'(`FPEC_WIN_CYC - 1);
                     tle_d = 1'b0;
                  end
                  else
                     state_d = idle_st;
               end
            fpec_pkg::FPEC_WINDOW:
               if (wr_i && is_cmd(wdata_i, `FPEC_CMD_SECT_ERASE))
               begin
                  // Each added sector restarts the window from this strobe
                  sect_d[sect_of(addr_i)] = 1'b1;
                  win_cnt_d = `FPEC_WIN_W'(`FPEC_WIN_CYC - 1);
               end
               else if (wr_i && is_cmd(wdata_i, `FPEC_CMD_SUSPEND))
               begin
                  state_d = fpec_pkg::FPEC_SUSP;
                  phase_d = fpec_pkg::FPEC_PH_PREPROG;
               end
               else if (wr_i)
               begin
                  state_d = idle_st;
                  sect_d = '0;
               end
               else if (win_cnt_q == '0)
               begin
                  state_d = fpec_pkg::FPEC_ERASE;
                  phase_d = fpec_pkg::FPEC_PH_PREPROG;
                  estart_d = 1'b1;
               end
               else
                  win_cnt_d = win_cnt_q - `FPEC_WIN_W'(1);
            fpec_pkg::FPEC_PROG:
               // Writes are dropped here; only completion moves on
               if (op_fail_i || (op_done_i && |(pd_q & ~old_data_i)))
               begin
                  state_d = fpec_pkg::FPEC_FAIL;
                  tle_d = 1'b1;
               end
               else if (op_done_i)
                  state_d = idle_st;
            fpec_pkg::FPEC_ERASE:
               if (op_fail_i)
               begin
                  state_d = fpec_pkg::FPEC_FAIL;
                  tle_d = 1'b1;
               end
               else if (!chip_q && wr_i && is_cmd(wdata_i, `FPEC_CMD_SUSPEND))
                  state_d = fpec_pkg::FPEC_SUSP;
               else if (op_done_i && phase_q == fpec_pkg::FPEC_PH_ERASE)
               begin
                  state_d = idle_st;
                  sect_d = '0;
                  chip_d = 1'b0;
               end
               else if (op_done_i)
                  // Preprogram to zeros, verify, then erase
                  phase_d = (phase_q == fpec_pkg::FPEC_PH_PREPROG)
                            ? fpec_pkg::FPEC_PH_VERIFY : fpec_pkg::FPEC_PH_ERASE;
            fpec_pkg::FPEC_SUSP:
               if (wr_i && is_cmd(wdata_i, `FPEC_CMD_RESUME))
               begin
                  state_d = fpec_pkg::FPEC_ERASE;
                  estart_d = (phase_q == fpec_pkg::FPEC_PH_PREPROG);
               end
            fpec_pkg::FPEC_FAIL:
               if (wr_i && is_cmd(wdata_i, `FPEC_CMD_RESET))
               begin
                  state_d = idle_st;
                  tle_d = 1'b0;
                  sect_d = '0;
                  chip_d = 1'b0;
               end
            fpec_pkg::FPEC_BYP:
               if (wr_i)
               begin
                  if (is_cmd(wdata_i, `FPEC_CMD_PROG))
                     state_d = fpec_pkg::FPEC_BYP_PSETUP;
                  else if (is_cmd(wdata_i, `FPEC_CMD_ERASE_SETUP))
                     state_d = fpec_pkg::FPEC_BYP_ESETUP;
                  else if (is_cmd(wdata_i, `FPEC_CMD_BYPASS_EXIT1))
                     state_d = fpec_pkg::FPEC_BYP_EXIT;
                  // Anything else is invalid and leaves bypass idle
               end
            fpec_pkg::FPEC_BYP_EXIT:
               if (wr_i)
               begin
                  if (is_cmd(wdata_i, `FPEC_CMD_BYPASS_EXIT2))
                  begin
                     // A held acceleration pin keeps the bank in bypass, going straight back to FPEC_BYP
                     bypass_d = 1'b0;
                     state_d = acc_sync_q ? fpec_pkg::FPEC_BYP : fpec_pkg::FPEC_READ;
                  end
                  else
                     state_d = fpec_pkg::FPEC_BYP;
               end
         endcase
         if (state_d == fpec_pkg::FPEC_READ && acc_sync_q)
            state_d = fpec_pkg::FPEC_BYP;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= fpec_pkg::FPEC_READ;
         phase_q <= fpec_pkg::FPEC_PH_PREPROG;
         bypass_q <= 1'b0;
         win_cnt_q <= '0;
         pa_q <= '0;
         pd_q <= '0;
         sect_q <= '0;
         chip_q <= 1'b0;
         pstart_q <= 1'b0;
         estart_q <= 1'b0;
         tle_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         phase_q <= phase_d;
         bypass_q <= bypass_d;
         win_cnt_q <= win_cnt_d;
         pa_q <= pa_d;
         pd_q <= pd_d;
         sect_q <= sect_d;
         chip_q <= chip_d;
         pstart_q <= pstart_d;
         estart_q <= estart_d;
         tle_q <= tle_d;
      end
   end

   // Read path: status inside the busy bank, array data elsewhere
   logic status_st;
   assign status_st = (state_q == fpec_pkg::FPEC_PROG) || (state_q == fpec_pkg::FPEC_ERASE)
                      || (state_q == fpec_pkg::FPEC_WINDOW) || (state_q == fpec_pkg::FPEC_FAIL)
                      || (state_q == fpec_pkg::FPEC_SUSP);

   logic tog_a_q, tog_a_d, tog_b_q, tog_b_d;
   logic [`FPEC_DATA_W-1:0] rdata_q, rdata_d;

   always_comb
   begin
      tog_a_d = tog_a_q;
      tog_b_d = tog_b_q;
      rdata_d = rdata_q;
      if (rd_i && rd_bank_hit_i && status_st)
      begin
         rdata_d = '0;
         // Poll bit shows the complement of the target bit until done
         rdata_d[`FPEC_BIT_POLL] = (state_q == fpec_pkg::FPEC_PROG) ? ~pd_q[7]
                                   : (state_q == fpec_pkg::FPEC_SUSP);
         rdata_d[`FPEC_BIT_TOGGLE_A] = tog_a_q;
         rdata_d[`FPEC_BIT_TOGGLE_B] = tog_b_q;
         rdata_d[`FPEC_BIT_TLE] = tle_q;
         rdata_d[`FPEC_BIT_TIMER] = (state_q != fpec_pkg::FPEC_WINDOW);
         // Toggle A freezes while suspended; toggle B keeps going
         tog_a_d = (state_q == fpec_pkg::FPEC_SUSP) ? tog_a_q : ~tog_a_q;
         tog_b_d = ~tog_b_q;
      end
      else if (rd_i)
         rdata_d = array_rd_data_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tog_a_q <= 1'b0;
         tog_b_q <= 1'b0;
         rdata_q <= '0;
      end
      else
      begin
         tog_a_q <= tog_a_d;
         tog_b_q <= tog_b_d;
         rdata_q <= rdata_d;
      end
   end

   assign rd_data_o = rdata_q;
   assign prog_start_o = pstart_q;
   assign prog_addr_o = pa_q;
   assign prog_data_o = pd_q;
   assign erase_start_o = estart_q;
   assign erase_chip_o = chip_q;
   assign erase_sectors_o = sect_q;
   assign erase_phase_o = phase_q;
   assign busy_o = status_st;
   assign bypass_o = byp_mode;

   prog_launch_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == fpec_pkg::FPEC_PSETUP && wr_i && !abort)
      |=> (prog_start_o && prog_addr_o == $past(addr_i) && state_q == fpec_pkg::FPEC_PROG))
      else $error("Program launch missing");

   prog_return_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == fpec_pkg::FPEC_PROG && op_done_i && !op_fail_i && !abort
       && !byp_mode && pd_q == (pd_q & old_data_i))
      |=> state_q == fpec_pkg::FPEC_READ)
      else $error("Program did not return to read");

   prog_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == fpec_pkg::FPEC_PROG && wr_i && !op_done_i && !op_fail_i && !abort)
      |=> (state_q == fpec_pkg::FPEC_PROG && !prog_start_o))
      else $error("Command accepted during program");

   hw_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!hw_reset_n_i ##1 !hw_reset_n_i ##1 !hw_reset_n_i)
      |=> (state_q == fpec_pkg::FPEC_READ && !bypass_q && !erase_chip_o))
      else $error("Hardware reset did not abort");

   bypass_enter_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == fpec_pkg::FPEC_UL2 && wr_i && !abort && wdata_i[7:0] == `FPEC_CMD_BYPASS
       && addr_i[10:0] == `FPEC_UNLOCK1_ADDR)
      |=> (bypass_o && state_q == fpec_pkg::FPEC_BYP))
      else $error("Bypass mode not entered");

   window_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q != fpec_pkg::FPEC_WINDOW ##1 state_q == fpec_pkg::FPEC_WINDOW)
      |-> (win_cnt_q == `FPEC_WIN_W'(`FPEC_WIN_CYC - 1) && erase_sectors_o != '0))
      else $error("Erase window length wrong");

   timer_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_i && rd_bank_hit_i && (state_q == fpec_pkg::FPEC_WINDOW
                                 || state_q == fpec_pkg::FPEC_ERASE))
      |=> rd_data_o[`FPEC_BIT_TIMER] == ($past(state_q) == fpec_pkg::FPEC_ERASE))
      else $error("Erase timer bit wrong");

   suspend_now_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == fpec_pkg::FPEC_WINDOW && wr_i && !abort
       && wdata_i[7:0] == `FPEC_CMD_SUSPEND)
      |=> (state_q == fpec_pkg::FPEC_SUSP && !erase_start_o))
      else $error("Suspend in window not immediate");

   seq_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ((state_q == fpec_pkg::FPEC_UL1 || state_q == fpec_pkg::FPEC_ESETUP
        || state_q == fpec_pkg::FPEC_EUL1) && wr_i && !abort && !acc_sync_q
       && wdata_i[7:0] == `FPEC_CMD_RESET)
      |=> state_q == fpec_pkg::FPEC_READ)
      else $error("Reset between cycles ignored");

   other_bank_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_i && !rd_bank_hit_i) |=> rd_data_o == $past(array_rd_data_i))
      else $error("Other bank read not array data");

endmodule

// >>> tb/fpec_engine_model.sv
// Behavioural array engine beside the command sequencer.
// Assumes one start pulse per operation and busy_i low once the bank is idle.
`include "fpec_defines.svh"
module fpec_engine_model #(parameter int DLY = 40)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic prog_start_i,
   input wire logic [`FPEC_ADDR_W-1:0] prog_addr_i,
   input wire logic erase_start_i,
   input wire logic busy_i,
   output logic op_done_o,
   output logic op_fail_o,
   output logic [`FPEC_DATA_W-1:0] old_data_o
);
   logic [1:0] pend_q;
   logic [7:0] cnt_q;
   timeunit 1ns;
   timeprecision 1ps;
   // Top quarter already holds zeros, so programming there raises bits
   assign old_data_o = (prog_addr_i[21:20] == 2'h3) ? 16'h0000 : '1;
   assign op_fail_o = 1'b0;
   always_ff @(posedge clk_i)
   begin
      op_done_o <= 1'b0;
      // An aborted operation drops its pending pulses
      if (rst_i || !busy_i)
      begin
         pend_q <= 2'h0;
         cnt_q <= 8'h00;
      end
      else if (prog_start_i || erase_start_i)
      begin
         pend_q <= prog_start_i ? 2'h1 : 2'h3;
         cnt_q <= 8'(DLY);
      end
      else if (pend_q != 2'h0)
      begin
         if (cnt_q == 8'h00)
         begin
            op_done_o <= 1'b1;
            pend_q <= pend_q - 2'h1;
            cnt_q <= 8'(DLY);
         end
         else
            cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule

// >>> tb/fpec_cmd_fsm_tb_top.sv
// Self-checking bench of the command sequencer with a behavioural engine.
// Assumes the sequencer's hand-over timing and a 40 MHz clock.
`include "fpec_defines.svh"
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin errors++; \
   $display("MISMATCH %0t %s", $time, m); end end
module fpec_cmd_fsm_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, hw_reset_n_i = 1, accel_program_input_i = 0;
   logic wr_i = 0, rd_i = 0, rd_bank_hit_i = 1, op_done_i, op_fail_i;
   logic [21:0] addr_i = '0;
   logic [15:0] wdata_i = '0, array_rd_data_i = 16'h1234, old_data_i, rd_data_o, rdv;
   logic [15:0] prog_data_o;
   logic [21:0] prog_addr_o;
   logic prog_start_o, erase_start_o, erase_chip_o, busy_o, bypass_o;
   logic [127:0] erase_sectors_o;
   logic [1:0] erase_phase_o;
   int errors = 0, samples_checked = 0, ps_n = 0, es_n = 0, p, n;
   fpec_cmd_fsm DUT (.clk_i, .rst_i, .hw_reset_n_i, .accel_program_input_i, .wr_i, .rd_i,
      .addr_i, .wdata_i, .rd_bank_hit_i, .array_rd_data_i, .old_data_i, .op_done_i,
      .op_fail_i, .rd_data_o, .prog_start_o, .prog_addr_o, .prog_data_o, .erase_start_o,
      .erase_chip_o, .erase_sectors_o, .erase_phase_o, .busy_o, .bypass_o);
   fpec_engine_model ENG (.clk_i, .rst_i, .prog_start_i(prog_start_o), .prog_addr_i(prog_addr_o),
      .erase_start_i(erase_start_o), .busy_i(busy_o), .op_done_o(op_done_i),
      .op_fail_o(op_fail_i), .old_data_o(old_data_i));
   initial forever #12.5 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      if (prog_start_o === 1'b1) ps_n++;
      if (erase_start_o === 1'b1) es_n++;
   end
   task close_out;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task wr(input logic [21:0] a, input logic [15:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task rd(input logic [21:0] a);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 rdv = rd_data_o;
   endtask
   task ul;
      wr(22'h555, 16'h00aa);
      wr(22'h2aa, 16'h0055);
   endtask
   task esetup;
      ul;
      wr(22'h555, 16'h0080);
      ul;
   endtask
   task idle;
      for (n = 0; n < 400 && busy_o !== 1'b0; n++) @(posedge clk_i);
      `CHK(busy_o, 1'b0, "bank stays busy")
   endtask
   task hwrst;
      hw_reset_n_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      #1 `CHK(busy_o, 1'b0, "hardware reset no abort")
      hw_reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
   endtask
   task t_prog;
      p = ps_n;
      ul;
      wr(22'h555, 16'h00a0);
      wr(22'h012345, 16'h5a3c);
      repeat (2) @(posedge clk_i);
      `CHK(ps_n, p + 1, "program not launched")
      `CHK(prog_addr_o, 22'h012345, "program address")
      `CHK(prog_data_o, 16'h5a3c, "program data")
      rd(22'h012345);
      `CHK(rdv[`FPEC_BIT_POLL], 1'b1, "poll bit")
      p = rdv[`FPEC_BIT_TOGGLE_A];
      rd(22'h012345);
      `CHK(rdv[`FPEC_BIT_TOGGLE_A], ~1'(p), "toggle bit")
      rd_bank_hit_i <= 1'b0;
      rd(22'h000000);
      `CHK(rdv, 16'h1234, "other bank read")
      rd_bank_hit_i <= 1'b1;
      p = ps_n;
      ul;
      wr(22'h555, 16'h00a0);
      wr(22'h000010, 16'h0000);
      `CHK(ps_n, p, "command taken while programming")
      idle;
      rd(22'h012345);
      `CHK(rdv, 16'h1234, "no array read after program")
   endtask
   task t_bypass;
      ul;
      wr(22'h555, 16'h0020);
      `CHK(bypass_o, 1'b1, "bypass not entered")
      p = ps_n;
      wr(22'h000000, 16'h0055);
      wr(22'h000000, 16'h00a0);
      wr(22'h000100, 16'h00ff);
      repeat (2) @(posedge clk_i);
      `CHK(ps_n, p + 1, "bypass program")
      idle;
      `CHK(bypass_o, 1'b1, "bypass lost after program")
      p = es_n;
      wr(22'h000000, 16'h0080);
      wr(22'h000000, 16'h0010);
      repeat (2) @(posedge clk_i);
      `CHK(es_n, p + 1, "bypass chip erase")
      `CHK(erase_chip_o, 1'b1, "chip flag")
      hwrst;
      ul;
      wr(22'h555, 16'h0020);
      wr(22'h000000, 16'h0090);
      wr(22'h3fffff, 16'h0000);
      `CHK(bypass_o, 1'b0, "bypass not left")
   endtask
   task t_chip;
      p = es_n;
      esetup;
      wr(22'h555, 16'h0010);
      repeat (2) @(posedge clk_i);
      `CHK(es_n, p + 1, "chip erase start")
      `CHK(erase_sectors_o, {128{1'b1}}, "chip sector set")
      wr(22'h000000, 16'h00f0);
      `CHK(busy_o, 1'b1, "reset taken in chip erase")
      hwrst;
   endtask
   task t_sector;
      p = es_n;
      esetup;
      wr(22'h008000, 16'h0030);
      rd(22'h008000);
      `CHK(rdv[`FPEC_BIT_TIMER], 1'b0, "timer bit in window")
      wr(22'h028000, 16'h0030);
      @(posedge clk_i);
      #1 `CHK(erase_sectors_o, 128'h22, "sector set")
      for (n = 0; n < 1600 && es_n == p; n++) @(posedge clk_i);
      `CHK(n >= 1400, 1'b1, "window too short")
      `CHK(es_n, p + 1, "sector erase start")
      rd(22'h008000);
      `CHK(rdv[`FPEC_BIT_TIMER], 1'b1, "timer bit after window")
      wr(22'h000000, 16'h00f0);
      `CHK(busy_o, 1'b1, "reset taken in erase")
      idle;
      rd(22'h008000);
      `CHK(rdv, 16'h1234, "no array read after erase")
   endtask
   task t_abort;
      esetup;
      wr(22'h008000, 16'h0030);
      wr(22'h000000, 16'h0055);
      `CHK(busy_o, 1'b0, "window not left")
      p = ps_n;
      ul;
      wr(22'h000000, 16'h00f0);
      wr(22'h555, 16'h00a0);
      wr(22'h000200, 16'h0000);
      wr(22'h555, 16'h00aa);
      wr(22'h2aa, 16'h0056);
      wr(22'h555, 16'h00a0);
      wr(22'h000200, 16'h0000);
      repeat (2) @(posedge clk_i);
      `CHK(ps_n, p, "aborted sequence programmed")
   endtask
   task t_fail;
      ul;
      wr(22'h555, 16'h00a0);
      wr(22'h300000, 16'h0001);
      repeat (60) @(posedge clk_i);
      rd(22'h300000);
      `CHK(rdv[`FPEC_BIT_TLE], 1'b1, "time limit bit")
      `CHK(busy_o, 1'b1, "failed program left status")
      wr(22'h000000, 16'h00f0);
      `CHK(busy_o, 1'b0, "reset after time limit")
   endtask
   task t_susp;
      p = es_n;
      esetup;
      wr(22'h010000, 16'h0030);
      wr(22'h000000, 16'h00b0);
      rd(22'h010000);
      `CHK(rdv[`FPEC_BIT_TIMER], 1'b1, "timer bit in suspend")
      `CHK(rdv[`FPEC_BIT_POLL], 1'b1, "poll bit in suspend")
      `CHK(es_n, p, "erase began despite suspend")
      wr(22'h000000, 16'h0030);
      repeat (2) @(posedge clk_i);
      `CHK(es_n, p + 1, "resume start")
      idle;
   endtask
   task t_accel;
      accel_program_input_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1 `CHK(bypass_o, 1'b1, "accel bypass")
      p = ps_n;
      wr(22'h000000, 16'h00a0);
      wr(22'h000300, 16'h0f0f);
      repeat (2) @(posedge clk_i);
      `CHK(ps_n, p + 1, "accel program")
      hwrst;
      accel_program_input_i <= 1'b0;
   endtask
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      t_prog;
      t_bypass;
      t_chip;
      t_sector;
      t_abort;
      t_fail;
      t_susp;
      t_accel;
      close_out;
   end
   // Whole run needs a few thousand cycles
   initial
   begin
      #(25 * 20000);
      errors++;
      close_out;
   end
endmodule
